// ---- inc/potc_pkg.sv ----
package potc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam int unsigned IDX_W = 16;
    localparam int unsigned ADR_W = 18;
    localparam int unsigned ADR_LSB = 2;
    localparam logic [15:0] IDX_PIN_STATE_LOW = 16'h00a0;
    localparam logic [15:0] IDX_TRIG_SEL = 16'h00a1;
    localparam logic [15:0] IDX_EN_HIGH = 16'h00a2;
    localparam logic [15:0] IDX_EN_LOW = 16'h00a3;
    localparam logic [15:0] IDX_ND_HIGH_PRI = 16'hffa4;
    localparam logic [15:0] IDX_ND_LOW_PRI = 16'hffa5;
    localparam logic [15:0] IDX_ND_HIGH_ALT = 16'hffa6;
    localparam logic [15:0] IDX_ND_LOW_ALT = 16'hffa7;
    localparam logic [15:0] IDX_PIN_STATE_HIGH = 16'hffa8;

    // Field layout.
    localparam int unsigned N_GROUPS = 4;
    localparam int unsigned N_CHAN = 4;
    localparam int unsigned GROUP_W = 4;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned REG_W = 8;
    localparam int unsigned BUS_W = 32;

    // Reset and fixed read values.
    localparam logic [7:0] TRIG_SEL_RST = 8'h00;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] NEXT_DATA_RST = 8'h00;
    localparam logic [7:0] PINS_RST = 8'h00;
    localparam logic [7:0] UNUSED_BYTE = 8'hff;
    localparam logic [3:0] UNUSED_NIBBLE = 4'hf;

    // Extracts the trigger-select field of one group.
    function automatic logic [1:0] sel_field(input logic [7:0] sel, input int unsigned grp);
        sel_field = sel[grp * SEL_W +: SEL_W];
    endfunction : sel_field

endpackage : potc_pkg

// ---- hdl/potc_trig_route.sv ----
`timescale 1ns/1ns
module potc_trig_route (
    input wire logic [7:0] i_trig_sel,
    input wire logic [3:0] i_cmp_match,
    output logic [3:0] o_group_fire,
    output logic o_same_low,
    output logic o_same_high
);
    // Each group follows the channel its 2-bit field names, code n meaning channel n.
    always_comb begin
        for (int unsigned g = 0; g < potc_pkg::N_GROUPS; g++) begin
            o_group_fire[g] = i_cmp_match[potc_pkg::sel_field(i_trig_sel, g)];
        end
        o_same_low = potc_pkg::sel_field(i_trig_sel, 0) == potc_pkg::sel_field(i_trig_sel, 1);
        o_same_high = potc_pkg::sel_field(i_trig_sel, 2) == potc_pkg::sel_field(i_trig_sel, 3);
    end
endmodule : potc_trig_route

// ---- hdl/potc_out_group.sv ----
`timescale 1ns/1ns
module potc_out_group #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_fire,
    input wire logic [WIDTH-1:0] i_enable,
    input wire logic [WIDTH-1:0] i_next,
    output logic [WIDTH-1:0] o_pins
);
    typedef struct packed {
        logic [WIDTH-1:0] pins;
    } potc_grp_state_t;

    potc_grp_state_t st_r;
    potc_grp_state_t st_nxt;

    // Disabled bits keep their level, so software can hand single pins back to plain port use.
    always_comb begin
        st_nxt = st_r;
        if (i_fire) begin
            st_nxt.pins = (i_next & i_enable) | (st_r.pins & ~i_enable);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r.pins <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_pins = st_r.pins;
endmodule : potc_out_group

// ---- hdl/potc_top.sv ----
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
// Overview of operation
// - Bits 1:0 of the trigger select register pick group 0's timer channel.
// - Bits 3:2 of the trigger select register pick group 1's timer channel.
// - Group 2 select codes 00 to 11 pick timer channels 0 to 3.
// - Bits 7:6 pick group 3's channel, codes 00 to 11 meaning channels 0 to 3.
// - High enable bits 3:0 gate copying pending data onto port high bits 3:0.
// - Low enable bits 7:0 gate copying pending data onto port low bits 7:0.
// - Shared trigger: lower high-data address holds all eight bits, read/write, reset zero.
// - Shared trigger: upper high-data address reads all ones and ignores writes.
// - Separate triggers: lower high-data address keeps bits 7:4, bits 3:0 read ones.
module potc_top (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [17:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic [3:0] i_cmp_match,
    output logic [7:0] o_port_low_pin,
    output logic [7:0] o_port_high_pin
);

    typedef struct packed {
        logic [7:0] trig_sel;
        logic [7:0] en_high;
        logic [7:0] en_low;
        logic [7:0] nd_high;
        logic [7:0] nd_low;
        logic ack;
        logic [31:0] rdata;
    } potc_state_t;

    potc_state_t st_r;
    potc_state_t st_nxt;

    logic [3:0] group_fire;
    logic same_low;
    logic same_high;
    logic [15:0] req_idx;
    logic req_go;
    logic wr_go;

    // Reads one byte of a next-data pair as software sees it in the current trigger mode.
    function automatic logic [7:0] nd_read(
        input logic [7:0] val,
        input logic is_alt,
        input logic same
    );
        logic [7:0] r;
        r = potc_pkg::UNUSED_BYTE;
        if (same) begin
            if (!is_alt) begin
                r = val;
            end
        end else if (is_alt) begin
            r = {potc_pkg::UNUSED_NIBBLE, val[3:0]};
        end else begin
            r = {val[7:4], potc_pkg::UNUSED_NIBBLE};
        end
        return r;
    endfunction : nd_read

    // Merges a software write into a next-data pair; bits that are unused in this mode stay put.
    function automatic logic [7:0] nd_write(
        input logic [7:0] val,
        input logic [7:0] wdata,
        input logic is_alt,
        input logic same
    );
        logic [7:0] r;
        r = val;
        if (same) begin
            if (!is_alt) begin
                r = wdata;
            end
        end else if (is_alt) begin
            r = {val[7:4], wdata[3:0]};
        end else begin
            r = {wdata[7:4], val[3:0]};
        end
        return r;
    endfunction : nd_write

    // Routing of compare matches to groups.
    potc_trig_route u_route (
        .i_trig_sel(st_r.trig_sel),
        .i_cmp_match(i_cmp_match),
        .o_group_fire(group_fire),
        .o_same_low(same_low),
        .o_same_high(same_high)
    );

    // Output groups 0 and 1 drive the low port.
    potc_out_group #(
        .WIDTH(potc_pkg::GROUP_W)
    ) u_group0 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_fire(group_fire[0]),
        .i_enable(st_r.en_low[3:0]),
        .i_next(st_r.nd_low[3:0]),
        .o_pins(o_port_low_pin[3:0])
    );

    potc_out_group #(
        .WIDTH(potc_pkg::GROUP_W)
    ) u_group1 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_fire(group_fire[1]),
        .i_enable(st_r.en_low[7:4]),
        .i_next(st_r.nd_low[7:4]),
        .o_pins(o_port_low_pin[7:4])
    );

    // Output groups 2 and 3 drive the high port.
    potc_out_group #(
        .WIDTH(potc_pkg::GROUP_W)
    ) u_group2 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_fire(group_fire[2]),
        .i_enable(st_r.en_high[3:0]),
        .i_next(st_r.nd_high[3:0]),
        .o_pins(o_port_high_pin[3:0])
    );

    potc_out_group #(
        .WIDTH(potc_pkg::GROUP_W)
    ) u_group3 (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_fire(group_fire[3]),
        .i_enable(st_r.en_high[7:4]),
        .i_next(st_r.nd_high[7:4]),
        .o_pins(o_port_high_pin[7:4])
    );

    assign req_idx = i_wb_adr[potc_pkg::ADR_W-1:potc_pkg::ADR_LSB];
    // The ack term makes every access take exactly one wait-free answer cycle and drop it after.
    assign req_go = i_wb_cyc && i_wb_stb && !st_r.ack;
    assign wr_go = req_go && i_wb_we && i_wb_sel[0];

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req_go;
        st_nxt.rdata = '0;
        if (wr_go) begin
            unique case (req_idx)
                potc_pkg::IDX_TRIG_SEL: begin
                    st_nxt.trig_sel = i_wb_dat[7:0];
                end
                potc_pkg::IDX_EN_HIGH: begin
                    st_nxt.en_high = i_wb_dat[7:0];
                end
                potc_pkg::IDX_EN_LOW: begin
                    st_nxt.en_low = i_wb_dat[7:0];
                end
                potc_pkg::IDX_ND_HIGH_PRI: begin
                    st_nxt.nd_high = nd_write(st_r.nd_high, i_wb_dat[7:0], 1'b0, same_high);
                end
                potc_pkg::IDX_ND_HIGH_ALT: begin
                    st_nxt.nd_high = nd_write(st_r.nd_high, i_wb_dat[7:0], 1'b1, same_high);
                end
                potc_pkg::IDX_ND_LOW_PRI: begin
                    st_nxt.nd_low = nd_write(st_r.nd_low, i_wb_dat[7:0], 1'b0, same_low);
                end
                potc_pkg::IDX_ND_LOW_ALT: begin
                    st_nxt.nd_low = nd_write(st_r.nd_low, i_wb_dat[7:0], 1'b1, same_low);
                end
                default: begin
                    // Unmapped or read-only: acknowledged and dropped.
                end
            endcase
        end
        if (req_go && !i_wb_we) begin
            unique case (req_idx)
                potc_pkg::IDX_TRIG_SEL: begin
                    st_nxt.rdata[7:0] = st_r.trig_sel;
                end
                potc_pkg::IDX_EN_HIGH: begin
                    st_nxt.rdata[7:0] = st_r.en_high;
                end
                potc_pkg::IDX_EN_LOW: begin
                    st_nxt.rdata[7:0] = st_r.en_low;
                end
                potc_pkg::IDX_ND_HIGH_PRI: begin
                    st_nxt.rdata[7:0] = nd_read(st_r.nd_high, 1'b0, same_high);
                end
                potc_pkg::IDX_ND_HIGH_ALT: begin
                    st_nxt.rdata[7:0] = nd_read(st_r.nd_high, 1'b1, same_high);
                end
                potc_pkg::IDX_ND_LOW_PRI: begin
                    st_nxt.rdata[7:0] = nd_read(st_r.nd_low, 1'b0, same_low);
                end
                potc_pkg::IDX_ND_LOW_ALT: begin
                    st_nxt.rdata[7:0] = nd_read(st_r.nd_low, 1'b1, same_low);
                end
                potc_pkg::IDX_PIN_STATE_LOW: begin
                    st_nxt.rdata[7:0] = o_port_low_pin;
                end
                potc_pkg::IDX_PIN_STATE_HIGH: begin
                    st_nxt.rdata[7:0] = o_port_high_pin;
                end
                default: begin
                    // Unmapped reads return zero so a stray access never hangs the bus.
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r.trig_sel <= potc_pkg::TRIG_SEL_RST;
            st_r.en_high <= potc_pkg::ENABLE_RST;
            st_r.en_low <= potc_pkg::ENABLE_RST;
            st_r.nd_high <= potc_pkg::NEXT_DATA_RST;
            st_r.nd_low <= potc_pkg::NEXT_DATA_RST;
            st_r.ack <= 1'b0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_ack = st_r.ack;
    assign o_wb_dat = st_r.rdata;

endmodule : potc_top

// ---- verification/potc_chk.sv ----
`timescale 1ns/1ns
module potc_chk (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [17:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [3:0] i_cmp_match,
    input wire logic [7:0] o_port_low_pin,
    input wire logic [7:0] o_port_high_pin
);
    // Shadow copies of the control registers, updated at the edge that takes a write.
    logic [7:0] ts_r, el_r, eh_r;
    logic wr;
    logic rd;
    logic same_hi;
    assign wr = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
    assign rd = o_wb_ack && i_wb_cyc && !i_wb_we;
    assign same_hi = ts_r[5:4] == ts_r[7:6];
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ts_r <= 8'h00;
            el_r <= 8'h00;
            eh_r <= 8'h00;
        end else if (wr) begin
            if (i_wb_adr[17:2] == potc_pkg::IDX_TRIG_SEL) ts_r <= i_wb_dat[7:0];
            if (i_wb_adr[17:2] == potc_pkg::IDX_EN_LOW) el_r <= i_wb_dat[7:0];
            if (i_wb_adr[17:2] == potc_pkg::IDX_EN_HIGH) eh_r <= i_wb_dat[7:0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    a_ack_next: assert property (s_req |=> o_wb_ack) else $error("ack missing");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    a_grp0_quiet: assert property (!i_cmp_match[ts_r[1:0]] |=> $stable(o_port_low_pin[3:0]))
        else $error("group 0 moved");
    a_grp1_quiet: assert property (!i_cmp_match[ts_r[3:2]] |=> $stable(o_port_low_pin[7:4]))
        else $error("group 1 moved");
    a_grp2_quiet: assert property (!i_cmp_match[ts_r[5:4]] |=> $stable(o_port_high_pin[3:0]))
        else $error("group 2 moved");
    a_grp3_quiet: assert property (!i_cmp_match[ts_r[7:6]] |=> $stable(o_port_high_pin[7:4]))
        else $error("group 3 moved");
    a_low_gate: assert property (((o_port_low_pin ^ $past(o_port_low_pin)) & ~$past(el_r)) == 8'h00)
        else $error("disabled low pin moved");
    a_high_gate: assert property (((o_port_high_pin ^ $past(o_port_high_pin)) & ~$past(eh_r)) == 8'h00)
        else $error("disabled high pin moved");
    a_alt_ones: assert property (rd && i_wb_adr[17:2] == potc_pkg::IDX_ND_HIGH_ALT && same_hi |->
        o_wb_dat == 32'h000000ff) else $error("alternate not all ones");
    a_pri_ones: assert property (rd && i_wb_adr[17:2] == potc_pkg::IDX_ND_HIGH_PRI && !same_hi |->
        o_wb_dat[3:0] == 4'hf) else $error("primary low nibble not ones");
endmodule : potc_chk
bind potc_top potc_chk chk_u (.i_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cmp_match, .o_port_low_pin, .o_port_high_pin);

// ---- verification/potc_timer_model.sv ----
`timescale 1ns/1ns
module potc_timer_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_arm,
    input wire logic [1:0] i_chan,
    input wire logic [3:0] i_wait,
    output logic [3:0] o_cmp_match
);
    // A variable wait lets a match arrive promptly or late after the registers settle.
    logic [4:0] cnt_r;
    logic [1:0] ch_r;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= 5'h00;
            ch_r <= 2'h0;
            o_cmp_match <= 4'h0;
        end else begin
            o_cmp_match <= (cnt_r == 5'h01) ? (4'h1 << ch_r) : 4'h0;
            if (i_arm) begin
                cnt_r <= {1'b0, i_wait} + 5'h01;
                ch_r <= i_chan;
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end
        end
    end
endmodule : potc_timer_model

// ---- verification/potc_top_bench.sv ----
`timescale 1ns/1ns
module potc_top_bench;
    logic i_clk = 1'b0, i_reset = 1'b1, cyc = 1'b0, we = 1'b0, arm = 1'b0, o_wb_ack;
    logic [17:0] adr = 18'h0;
    logic [31:0] wd = 32'h0, seed = 32'h107b5eab, o_wb_dat;
    logic [7:0] pl = 8'h00, ph = 8'h00, ts, el, eh, nh, nl, ex, o_port_low_pin, o_port_high_pin;
    logic [3:0] cm, wt = 4'h0;
    logic [1:0] ch = 2'h0;
    logic [7:0] q[$];
    int err_count = 0, checks_done = 0;
    always #5 i_clk = ~i_clk;
    potc_top dut_u (.i_clk, .i_reset, .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat(wd), .o_wb_dat, .o_wb_ack, .i_cmp_match(cm), .o_port_low_pin,
        .o_port_high_pin);
    potc_timer_model tm_u (.i_clk, .i_reset, .i_arm(arm), .i_chan(ch), .i_wait(wt), .o_cmp_match(cm));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    task automatic print_verdict;
        $display("mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [7:0] e);
        int n;
        @(posedge i_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wd <= {24'h0, d};
        if (!w) q.push_back(e);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (!o_wb_ack && n < 20);
        if (o_wb_ack !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, o_wb_ack, 1'b1);
            print_verdict();
        end else begin
            cyc <= 1'b0;
        end
    endtask : wb
    // The read monitor pops the oldest expectation whenever a read is answered.
    always @(posedge i_clk) begin
        if (o_wb_ack && cyc && !we) begin
            ex = q.pop_front();
            checks_done++;
            if (o_wb_dat !== {24'h0, ex}) begin
                err_count++;
                $display("unexpected at %0t: got %h expected %h", $time, o_wb_dat, {24'h0, ex});
            end
        end
    end
    task automatic wnd(input logic [15:0] p, input logic same, output logic [7:0] nd);
        logic [7:0] a, b;
        seed = nx(seed);
        a = seed[7:0];
        b = seed[15:8];
        nd = same ? a : {a[7:4], b[3:0]};
        wb(1'b1, p, a, 8'h00);
        wb(1'b1, p + 16'h0002, b, 8'h00);
        wb(1'b0, p, 8'h00, same ? a : {a[7:4], 4'hf});
        wb(1'b0, p + 16'h0002, 8'h00, same ? 8'hff : {4'hf, b[3:0]});
    endtask : wnd
    initial begin
        int i;
        logic [7:0] m;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        wb(1'b0, potc_pkg::IDX_TRIG_SEL, 8'h00, potc_pkg::TRIG_SEL_RST);
        wb(1'b0, potc_pkg::IDX_ND_HIGH_PRI, 8'h00, potc_pkg::NEXT_DATA_RST);
        wb(1'b0, potc_pkg::IDX_ND_HIGH_ALT, 8'h00, potc_pkg::UNUSED_BYTE);
        wb(1'b1, 16'h0050, 8'h5a, 8'h00);
        wb(1'b0, 16'h0050, 8'h00, 8'h00);
        for (i = 0; i < 24; i++) begin
            seed = nx(seed);
            ts = (i < 4) ? {4{i[1:0]}} : seed[7:0];
            el = seed[15:8];
            eh = seed[23:16];
            wb(1'b1, potc_pkg::IDX_TRIG_SEL, ts, 8'h00);
            wb(1'b1, potc_pkg::IDX_EN_LOW, el, 8'h00);
            wb(1'b1, potc_pkg::IDX_EN_HIGH, eh, 8'h00);
            wb(1'b0, potc_pkg::IDX_TRIG_SEL, 8'h00, ts);
            wb(1'b0, potc_pkg::IDX_EN_LOW, 8'h00, el);
            wb(1'b0, potc_pkg::IDX_EN_HIGH, 8'h00, eh);
            wnd(potc_pkg::IDX_ND_HIGH_PRI, ts[5:4] == ts[7:6], nh);
            wnd(potc_pkg::IDX_ND_LOW_PRI, ts[1:0] == ts[3:2], nl);
            @(posedge i_clk);
            ch <= i[1:0];
            wt <= seed[27:24];
            arm <= 1'b1;
            @(posedge i_clk);
            arm <= 1'b0;
            m = {{4{ts[3:2] == i[1:0]}}, {4{ts[1:0] == i[1:0]}}} & el;
            pl = (pl & ~m) | (nl & m);
            m = {{4{ts[7:6] == i[1:0]}}, {4{ts[5:4] == i[1:0]}}} & eh;
            ph = (ph & ~m) | (nh & m);
            repeat (20) @(posedge i_clk);
            // The pins are looked at directly too, so a fault in the pin-state read path cannot hide them.
            checks_done++;
            if ({o_port_high_pin, o_port_low_pin} !== {ph, pl}) begin
                err_count++;
                $display("unexpected at %0t: got %h expected %h", $time, {o_port_high_pin, o_port_low_pin}, {ph, pl});
            end
            wb(1'b0, potc_pkg::IDX_PIN_STATE_LOW, 8'h00, pl);
            wb(1'b0, potc_pkg::IDX_PIN_STATE_HIGH, 8'h00, ph);
        end
        print_verdict();
    end
endmodule : potc_top_bench
